/* pkg/uhpf_pkg.sv */
// constants and types for the usb host port full-speed handoff link
package uhpf_pkg;
	// ----------------------------------------
	// timing
	// ----------------------------------------
	localparam longint LINK_PERIOD_PS = 15000;
	localparam longint ATTACH_DEBOUNCE_US = 100000;
	localparam longint BUS_RESET_US = 10000;
	localparam longint DISCONNECT_NS = 2500;
	localparam int ATTACH_CYC = int'((ATTACH_DEBOUNCE_US * 1000000 + LINK_PERIOD_PS - 1)
		/ LINK_PERIOD_PS);
	localparam int RESET_CYC = int'((BUS_RESET_US * 1000000 + LINK_PERIOD_PS - 1)
		/ LINK_PERIOD_PS);
	localparam int DISC_CYC = int'((DISCONNECT_NS * 1000 + LINK_PERIOD_PS - 1)
		/ LINK_PERIOD_PS);
	localparam int CNT_W = 24;
	// ----------------------------------------
	// transceiver register writes
	// ----------------------------------------
	localparam logic [7:0] FUNC_CTRL_WR_CMD = 8'h84;
	localparam logic [7:0] IFC_CTRL_WR_CMD = 8'h87;
	localparam logic [7:0] FC_RESET_VAL = 8'h50;
	localparam logic [7:0] FC_FS_VAL = 8'h45;
	localparam logic [7:0] IFC_SERIAL_VAL = 8'h01;
	localparam logic [7:0] BUS_IDLE = 8'h00;
	// ----------------------------------------
	// line state and serial pin layout
	// ----------------------------------------
	localparam logic [1:0] LS_SE0 = 2'h0;
	localparam logic [1:0] LS_K = 2'h2;
	localparam int LS_LSB = 0;
	localparam int SER_TX_LSB = 0;
	localparam int SER_DP_BIT = 5;
	localparam int SER_DM_BIT = 6;
	localparam int SER_RCV_BIT = 7;
	localparam logic [7:0] SER_OE = 8'h07;
	localparam int FLG_W = 6;
	typedef enum logic [3:0] {
		L_IDLE = 4'h0,
		L_WRITE = 4'h1,
		L_RESET = 4'h2,
		L_HS = 4'h3,
		L_FS = 4'h4,
		L_SERIAL = 4'h5
	} uhpf_link_e;
	typedef struct packed {
		logic [1:0] rs;
		logic own_m;
		logic own_s;
		logic [2:0] ctx_m;
		logic [2:0] ctx_s;
		uhpf_link_e st;
		uhpf_link_e ret;
		logic ph;
		logic [7:0] wcmd;
		logic [7:0] wval;
		logic [CNT_W-1:0] cnt;
		logic chirp;
		logic dir_prev;
		logic [1:0] ls;
		logic [7:0] dout;
		logic stp;
		logic [FLG_W-1:0] flg;
	} uhpf_link_s;
	typedef struct packed {
		logic [FLG_W-1:0] m;
		logic [FLG_W-1:0] s;
	} uhpf_sys_s;
endpackage

/* logic/uhpf_port.sv */
// usb host port link: attach, bus reset, speed check and companion handoff
`timescale 1ns/10ps
// What this block does
// - detect attach, drive bus reset, decide whether the device is full speed
// - after handoff companion sees the connection and carries the traffic
// - in high-speed mode dir at one makes the link release the data lines
// - in serial mode the link drives its transmit lines although dir is one
// - full-speed traffic works on a companion-owned port
module uhpf_port import uhpf_pkg::*; #(
	parameter int ATTACH_CYCLES = ATTACH_CYC,
	parameter int RESET_CYCLES = RESET_CYC
) (
	input wire logic clk,
	input wire logic rst,
	input wire logic ulpi_clk,
	input wire logic ulpi_dir,
	input wire logic ulpi_nxt,
	input wire logic [7:0] ulpi_data_i,
	output logic [7:0] ulpi_data_o,
	output logic [7:0] ulpi_data_oe,
	output logic ulpi_stp,
	input wire logic port_owner_bit,
	input wire logic comp_tx_en,
	input wire logic comp_tx_dat,
	input wire logic comp_tx_se0,
	output logic hs_connect,
	output logic fs_device_found,
	output logic comp_connect,
	output logic comp_rx_dp,
	output logic comp_rx_dm,
	output logic comp_rx_rcv
);
	// ----------------------------------------
	// link domain
	// ----------------------------------------
	uhpf_link_s lq, ln;
	uhpf_sys_s sq, sn;
	logic rst_l;
	logic rxcmd;

	function automatic uhpf_link_s start_wr(uhpf_link_s s, logic [7:0] c, logic [7:0] v,
		uhpf_link_e r);
		uhpf_link_s o;
		o = s;
		o.st = L_WRITE;
		o.ret = r;
		o.wcmd = c;
		o.wval = v;
		o.dout = c;
		o.ph = 1'b0;
		return o;
	endfunction

	assign rst_l = lq.rs[1];
	assign rxcmd = ulpi_dir & lq.dir_prev & ~ulpi_nxt & (lq.st != L_SERIAL);

	always_comb begin
		ln = lq;
		ln.rs = {lq.rs[0], rst};
		ln.own_m = port_owner_bit;
		ln.own_s = lq.own_m;
		ln.ctx_m = {comp_tx_se0, comp_tx_dat, comp_tx_en};
		ln.ctx_s = lq.ctx_m;
		ln.dir_prev = ulpi_dir;
		ln.stp = 1'b0;
		if (rxcmd) begin
			ln.ls = ulpi_data_i[LS_LSB +: 2];
		end
		unique case (lq.st)
			L_IDLE: begin
				ln.dout = BUS_IDLE;
				if (lq.ls == LS_SE0) begin
					ln.cnt = '0;
				end else if (lq.cnt == CNT_W'(ATTACH_CYCLES - 1)) begin
					// attach seen long enough: start bus reset
					ln = start_wr(ln, FUNC_CTRL_WR_CMD, FC_RESET_VAL, L_RESET);
					ln.cnt = '0;
					ln.chirp = 1'b0;
				end else begin
					ln.cnt = lq.cnt + 1'b1;
				end
			end
			L_WRITE: begin
				if (ulpi_dir) begin
					// transceiver took the bus: retry from the command byte
					ln.ph = 1'b0;
					ln.dout = lq.wcmd;
				end else if (ulpi_nxt && !lq.ph) begin
					ln.ph = 1'b1;
					ln.dout = lq.wval;
				end else if (ulpi_nxt) begin
					ln.ph = 1'b0;
					ln.dout = BUS_IDLE;
					ln.stp = 1'b1;
					ln.st = lq.ret;
					ln.cnt = '0;
				end
			end
			L_RESET: begin
				if (lq.ls == LS_K) begin
					ln.chirp = 1'b1;
				end
				if (lq.cnt == CNT_W'(RESET_CYCLES - 1)) begin
					ln.cnt = '0;
					if (lq.chirp || lq.ls == LS_K) begin
						ln.st = L_HS;
					end else begin
						ln = start_wr(ln, FUNC_CTRL_WR_CMD, FC_FS_VAL, L_FS);
					end
				end else begin
					ln.cnt = lq.cnt + 1'b1;
				end
			end
			L_HS, L_FS: begin
				if (lq.st == L_FS && lq.own_s) begin
					// software gave the port away: switch transceiver to serial
					ln = start_wr(ln, IFC_CTRL_WR_CMD, IFC_SERIAL_VAL, L_SERIAL);
				end else if (lq.ls != LS_SE0) begin
					ln.cnt = '0;
				end else if (lq.cnt == CNT_W'(DISC_CYC - 1)) begin
					ln.st = L_IDLE;
					ln.cnt = '0;
				end else begin
					ln.cnt = lq.cnt + 1'b1;
				end
			end
			L_SERIAL: begin
				// companion drives the transmit pins straight through
				ln.dout = {5'h00, lq.ctx_s};
				if (!lq.own_s) begin
					// owner withdrawn: stop ends serial mode
					ln.stp = 1'b1;
					ln.dout = BUS_IDLE;
					ln.st = L_IDLE;
					ln.cnt = '0;
					ln.ls = LS_SE0;
				end
			end
		endcase
		ln.flg[0] = (ln.st == L_HS);
		ln.flg[1] = (ln.st == L_FS) || (ln.st == L_SERIAL)
			|| (ln.st == L_WRITE && ln.ret == L_SERIAL);
		ln.flg[2] = (lq.st == L_SERIAL) && lq.own_s
			&& (ulpi_data_i[SER_DP_BIT] | ulpi_data_i[SER_DM_BIT]);
		ln.flg[3] = ulpi_data_i[SER_DP_BIT];
		ln.flg[4] = ulpi_data_i[SER_DM_BIT];
		ln.flg[5] = ulpi_data_i[SER_RCV_BIT];
		if (rst_l) begin
			ln = '0;
			ln.rs = {lq.rs[0], rst};
			ln.st = L_IDLE;
			ln.ret = L_IDLE;
			ln.dir_prev = ulpi_dir;
		end
	end

	always_ff @(posedge ulpi_clk) begin
		lq <= ln;
	end

	assign ulpi_data_o = lq.dout;
	assign ulpi_stp = lq.stp;
	// serial mode keeps transmit pins driven; otherwise dir releases the bus
	assign ulpi_data_oe = (lq.st == L_SERIAL) ? SER_OE : {8{~ulpi_dir}};

	// ----------------------------------------
	// system domain
	// ----------------------------------------
	always_comb begin
		sn.m = lq.flg;
		sn.s = sq.m;
		if (rst) begin
			sn = '0;
		end
	end

	always_ff @(posedge clk) begin
		sq <= sn;
	end

	assign hs_connect = sq.s[0];
	assign fs_device_found = sq.s[1];
	assign comp_connect = sq.s[2];
	assign comp_rx_dp = sq.s[3];
	assign comp_rx_dm = sq.s[4];
	assign comp_rx_rcv = sq.s[5];

	// ----------------------------------------
	// checks
	// ----------------------------------------
	a_hs_dir_release: assert property (@(posedge ulpi_clk) disable iff (rst_l)
		(lq.st != L_SERIAL && ulpi_dir) |-> ulpi_data_oe == 8'h00)
		else $error("data lines driven while dir high in high-speed mode");
	a_serial_tx_drive: assert property (@(posedge ulpi_clk) disable iff (rst_l)
		(lq.st == L_SERIAL && ulpi_dir) |-> ulpi_data_oe == 8'h07)
		else $error("serial transmit pins not driven");
	a_serial_tx_pass: assert property (@(posedge ulpi_clk) disable iff (rst_l)
		(lq.st == L_SERIAL && lq.own_s) |=> ulpi_data_o[2:0] == $past(lq.ctx_s))
		else $error("companion transmit not passed to pins");
	a_attach_reset: assert property (@(posedge ulpi_clk) disable iff (rst_l)
		(lq.st == L_IDLE && lq.ls != LS_SE0 && lq.cnt == CNT_W'(ATTACH_CYCLES - 1))
		|=> (lq.st == L_WRITE && lq.ret == L_RESET && ulpi_data_o == 8'h84))
		else $error("bus reset not started after attach");
	a_fs_decide: assert property (@(posedge ulpi_clk) disable iff (rst_l)
		(lq.st == L_RESET && lq.cnt == CNT_W'(RESET_CYCLES - 1) && !lq.chirp
		&& lq.ls != LS_K) |=> (lq.st == L_WRITE && lq.ret == L_FS))
		else $error("full-speed device not recognised");
	a_hs_decide: assert property (@(posedge ulpi_clk) disable iff (rst_l)
		(lq.st == L_RESET && lq.cnt == CNT_W'(RESET_CYCLES - 1) && lq.chirp)
		|=> lq.st == L_HS)
		else $error("high-speed device not recognised");
	a_owner_handoff: assert property (@(posedge ulpi_clk) disable iff (rst_l)
		(lq.st == L_FS && lq.own_s) |=> (lq.st == L_WRITE && lq.ret == L_SERIAL
		&& ulpi_data_o == 8'h87))
		else $error("handoff did not request serial mode");
	a_stp_single: assert property (@(posedge ulpi_clk) disable iff (rst_l)
		ulpi_stp |=> !ulpi_stp)
		else $error("stop held longer than one cycle");
	a_write_order: assert property (@(posedge ulpi_clk) disable iff (rst_l)
		(lq.st == L_WRITE && lq.ph && ulpi_nxt && !ulpi_dir) |=> (ulpi_stp
		&& ulpi_data_o == 8'h00))
		else $error("register write not closed by stop");
	a_conn_owner: assert property (@(posedge ulpi_clk) disable iff (rst_l)
		lq.flg[2] |-> $past(lq.own_s) && $past(lq.st) == L_SERIAL)
		else $error("companion connect without ownership");

	// ----------------------------------------
	// link control checks
	// ----------------------------------------
	a_reset_quiet: assert property (@(posedge ulpi_clk)
		rst_l |=> !ulpi_stp && ulpi_data_o == BUS_IDLE)
		else $error("link drives bus during reset");
	a_rxcmd_line: assert property (@(posedge ulpi_clk) disable iff (rst_l)
		rxcmd |=> lq.ls == $past(ulpi_data_i[LS_LSB +: 2]))
		else $error("line state not taken from receive command");
	a_idle_se0_clear: assert property (@(posedge ulpi_clk) disable iff (rst_l)
		(lq.st == L_IDLE && lq.ls == LS_SE0) |=> lq.cnt == '0)
		else $error("attach count not cleared by single-ended zero");
	a_attach_count: assert property (@(posedge ulpi_clk) disable iff (rst_l)
		lq.st == L_IDLE |-> lq.cnt < CNT_W'(ATTACH_CYCLES))
		else $error("attach count overran");
	a_reset_len: assert property (@(posedge ulpi_clk) disable iff (rst_l)
		lq.st == L_RESET |-> lq.cnt < CNT_W'(RESET_CYCLES))
		else $error("bus reset count overran");
	a_chirp_latch: assert property (@(posedge ulpi_clk) disable iff (rst_l)
		(lq.st == L_RESET && lq.ls == LS_K) |=> lq.chirp)
		else $error("chirp not remembered during bus reset");
	a_hs_flag: assert property (@(posedge ulpi_clk) disable iff (rst_l)
		lq.st == L_HS |-> lq.flg[0])
		else $error("high-speed flag missing");
	a_disconnect: assert property (@(posedge ulpi_clk) disable iff (rst_l)
		((lq.st == L_HS || (lq.st == L_FS && !lq.own_s)) && lq.ls == LS_SE0
		&& lq.cnt == CNT_W'(DISC_CYC - 1)) |=> lq.st == L_IDLE)
		else $error("detach not recognised");
	a_fs_oe: assert property (@(posedge ulpi_clk) disable iff (rst_l)
		(lq.st == L_FS && !ulpi_dir) |-> ulpi_data_oe == 8'hff)
		else $error("data lines not driven while link owns bus");

	// ----------------------------------------
	// register write checks
	// ----------------------------------------
	a_write_retry: assert property (@(posedge ulpi_clk) disable iff (rst_l)
		(lq.st == L_WRITE && ulpi_dir) |=> (lq.st == L_WRITE && !lq.ph
		&& ulpi_data_o == $past(lq.wcmd)))
		else $error("write not restarted after turnaround");
	a_write_value: assert property (@(posedge ulpi_clk) disable iff (rst_l)
		(lq.st == L_WRITE && !lq.ph && ulpi_nxt && !ulpi_dir)
		|=> (lq.ph && ulpi_data_o == $past(lq.wval)))
		else $error("value byte not placed after command");
	a_stp_idle_out: assert property (@(posedge ulpi_clk) disable iff (rst_l)
		ulpi_stp |-> ulpi_data_o == BUS_IDLE)
		else $error("stop with data on bus");

	// ----------------------------------------
	// serial mode checks
	// ----------------------------------------
	a_serial_entry: assert property (@(posedge ulpi_clk) disable iff (rst_l)
		lq.st == L_SERIAL |-> ($past(lq.st) == L_SERIAL || $past(lq.st) == L_WRITE))
		else $error("serial mode entered without register write");
	a_serial_hold: assert property (@(posedge ulpi_clk) disable iff (rst_l)
		(lq.st == L_SERIAL && lq.own_s) |=> lq.st == L_SERIAL)
		else $error("serial mode left while owner set");
	a_serial_exit: assert property (@(posedge ulpi_clk) disable iff (rst_l)
		(lq.st == L_SERIAL && !lq.own_s) |=> (lq.st == L_IDLE && ulpi_stp))
		else $error("serial mode not ended by stop");
	a_serial_mask: assert property (@(posedge ulpi_clk) disable iff (rst_l)
		lq.st == L_SERIAL |-> ulpi_data_o[7:3] == 5'h00)
		else $error("unused pins driven high in serial mode");
	a_fs_flag_serial: assert property (@(posedge ulpi_clk) disable iff (rst_l)
		lq.st == L_SERIAL |-> lq.flg[1])
		else $error("full-speed flag missing in serial mode");
	a_conn_line: assert property (@(posedge ulpi_clk) disable iff (rst_l)
		lq.flg[2] |-> $past(ulpi_data_i[SER_DP_BIT] | ulpi_data_i[SER_DM_BIT]))
		else $error("companion connect without line activity");

	// ----------------------------------------
	// system side checks
	// ----------------------------------------
	a_sys_reset_clear: assert property (@(posedge clk)
		rst |=> !hs_connect && !fs_device_found && !comp_connect)
		else $error("status flags not cleared by reset");
	a_sys_conn_fs: assert property (@(posedge clk) disable iff (rst)
		comp_connect |-> fs_device_found)
		else $error("companion connect without full-speed device");

	c_hs_found: cover property (@(posedge ulpi_clk) disable iff (rst_l) lq.st == L_HS);
	c_fs_found: cover property (@(posedge ulpi_clk) disable iff (rst_l) lq.st == L_FS);
	c_serial: cover property (@(posedge ulpi_clk) disable iff (rst_l)
		lq.st == L_SERIAL && lq.flg[2]);
	c_release: cover property (@(posedge ulpi_clk) disable iff (rst_l)
		lq.st == L_SERIAL ##1 lq.st == L_IDLE);
	c_detach: cover property (@(posedge ulpi_clk) disable iff (rst_l)
		lq.st == L_HS ##1 lq.st == L_IDLE);
endmodule

/* verification/uhpf_phy_model.sv */
// transceiver model at the far side of the link
`timescale 1ns/10ps
module uhpf_phy_model import uhpf_pkg::*; (
	input wire logic ulpi_clk,
	input wire logic [7:0] data_o,
	input wire logic stp,
	input wire logic [1:0] line_st,
	input wire logic [2:0] ser_rx,
	output logic dir = 1'b1,
	output logic nxt = 1'b0,
	output logic [7:0] phy_d = 8'h00,
	output logic serial = 1'b0,
	output logic [7:0] last_cmd = 8'h00,
	output logic [7:0] last_val = 8'h00
);
	logic got_cmd = 1'b0;
	always @(posedge ulpi_clk) begin
		if (serial) begin
			// serial mode: bus stays turned toward the link side
			dir <= 1'b1;
			nxt <= 1'b0;
			phy_d <= {ser_rx, 5'h00};
			if (stp) serial <= 1'b0;
		end else if (data_o != BUS_IDLE) begin
			dir <= 1'b0;
			nxt <= 1'b1;
			// released lines must not keep the last value
			phy_d <= ~phy_d;
			if (nxt && got_cmd) last_val <= data_o;
			if (nxt && !got_cmd) last_cmd <= data_o;
			if (nxt) got_cmd <= ~got_cmd;
		end else begin
			dir <= 1'b1;
			nxt <= 1'b0;
			phy_d <= {6'h00, line_st};
			got_cmd <= 1'b0;
			if (stp) serial <= (last_cmd == IFC_CTRL_WR_CMD) && (last_val == IFC_SERIAL_VAL);
		end
	end
endmodule

/* verification/usb_host_port_fs_handoff_test.sv */
// self-checking bench for the host port handoff link
`timescale 1ns/10ps
module usb_host_port_fs_handoff_test import uhpf_pkg::*;;
	localparam int RC = 40;
	logic clk = 0, ulpi_clk = 0, rst = 1, owner = 0;
	logic [2:0] ctx = 0, srx = 0;
	logic [1:0] ls = LS_SE0;
	logic dir, nxt, stp, serial, hs_c, fs_f, c_con, rdp, rdm, rrcv;
	logic [7:0] d_o, d_oe, d_i, phy_d, lcmd, lval;
	logic [31:0] seed = 32'h0000_002b, r;
	int errors = 0, compares = 0, i;
	always #2 clk = ~clk;
	initial #3.3 forever #7.5 ulpi_clk = ~ulpi_clk;
	assign d_i = (d_oe & d_o) | (~d_oe & phy_d);
	uhpf_port #(.ATTACH_CYCLES(20), .RESET_CYCLES(RC)) dut (.clk(clk), .rst(rst),
		.ulpi_clk(ulpi_clk), .ulpi_dir(dir), .ulpi_nxt(nxt), .ulpi_data_i(d_i),
		.ulpi_data_o(d_o), .ulpi_data_oe(d_oe), .ulpi_stp(stp), .port_owner_bit(owner),
		.comp_tx_en(ctx[0]), .comp_tx_dat(ctx[1]), .comp_tx_se0(ctx[2]),
		.hs_connect(hs_c), .fs_device_found(fs_f), .comp_connect(c_con),
		.comp_rx_dp(rdp), .comp_rx_dm(rdm), .comp_rx_rcv(rrcv));
	uhpf_phy_model phy (.ulpi_clk(ulpi_clk), .data_o(d_o), .stp(stp), .line_st(ls),
		.ser_rx(srx), .dir(dir), .nxt(nxt), .phy_d(phy_d), .serial(serial),
		.last_cmd(lcmd), .last_val(lval));
	// ----------------------------------------
	// helpers
	// ----------------------------------------
	task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string what);
		compares++;
		if (got !== exp) begin
			errors++;
			$display("mismatch %0t %s got %h exp %h", $time, what, got, exp);
		end
	endtask
	task automatic finish_test();
		$display("errors %0d compares %0d", errors, compares);
		if (errors == 0 && compares > 0) $display("No errors found");
		else $display("Errors were found");
		$finish;
	endtask
	function automatic logic [31:0] xs();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction
	task automatic lk(input int n);
		repeat (n) @(posedge ulpi_clk);
		@(posedge clk);
		#1;
	endtask
	task automatic wv(input logic [7:0] v);
		for (i = 0; i < 500 && !(stp === 1'b1 && lval === v); i++) lk(1);
	endtask
	task automatic attach(input logic hs);
		ls = 2'h1;
		wv(FC_RESET_VAL);
		chk(lcmd, FUNC_CTRL_WR_CMD, "reset cmd");
		ls = hs ? LS_K : LS_SE0;
		if (!hs) wv(FC_FS_VAL);
		ls = hs ? LS_K : 2'h1;
		lk(hs ? RC + 20 : 20);
	endtask
	// ----------------------------------------
	// sequence
	// ----------------------------------------
	initial begin
		#200000;
		errors++;
		finish_test();
	end
	initial begin
		repeat (20) @(posedge clk);
		#1 rst = 0;
		lk(4);
		chk({5'h00, hs_c, fs_f, c_con}, 8'h00, "reset flags");
		attach(1);
		chk({6'h00, hs_c, fs_f}, 8'h02, "hs speed");
		chk({dir, d_oe[6:0]}, 8'h80, "hs release");
		ls = LS_SE0;
		lk(DISC_CYC + 20);
		chk({7'h00, hs_c}, 8'h00, "detach");
		attach(0);
		chk(lval, FC_FS_VAL, "fs value");
		chk({5'h00, hs_c, fs_f, c_con}, 8'h02, "fs speed");
		owner = 1;
		for (i = 0; i < 200 && !serial; i++) lk(1);
		lk(10);
		chk({serial, dir, d_oe[5:0]}, 8'hc7, "serial drive");
		for (int k = 0; k < 16; k++) begin
			r = xs();
			ctx = r[2:0];
			srx = r[5:3];
			lk(8);
			chk({5'h00, d_o[2:0]}, {5'h00, ctx}, "tx path");
			chk({5'h00, rrcv, rdm, rdp}, {5'h00, srx}, "rx path");
			chk({7'h00, c_con}, {7'h00, srx[0] | srx[1]}, "comp connect");
		end
		owner = 0;
		lk(20);
		chk({6'h00, serial, fs_f}, 8'h00, "release");
		finish_test();
	end
endmodule
